// File: hdl/rxcfg_core.sv
/*
  Configuration registers, off command and sleep control of a polling
  receiver. Assumes an open-drain data line with a pull-up, an enable pin,
  and a bit-check engine on sys_clk reporting pass/fail pulses.
*/
`timescale 1ns/1ps
`include "rxcfg_consts.svh"

// Notes on behaviour
// R1 - Off command or enable low ends receiving
// R2 - Controller holds line low band-dependent time
// R3 - Overlong initial low erases the marker
// R4 - Off frame: bit one set, one sync
// R5 - Off ends after t1+t2+t3+bit time+t10, then sleep
// R6 - Enable rising edge starts sleep time
// R7 - Enable held low keeps receiver asleep
// R8 - Controller-only polling should use sleep zero
// R9 - Two 12-bit registers written over data line
// R10 - Lost contents shown by marker on line
// R11 - Reset loads defaults into both registers
// R12 - Bit one off; bit two selects register
// R13 - Operating frame field order as specified
// R14 - Limit frame: two 6-bit limits, defaults
// R15 - Band selects factor 8,4,2,1, default 00
// R16 - Both limits scaled by band factor
// R17 - Check count codes mean 0,3,6,9
// R18 - Aux pin follows level bit, default 0
// R19 - Sleep = value*factor*1024; 0 none, 31 permanent
// R20 - Sleep factor 8 if any bit; temp reverts
// R21 - Lower limit*factor; upper minus one*factor
// R22 - Controller keeps limits at 10/12 or more
// R23 - Frame bits sent MSB first, one per sync
module rxcfg_core import rxcfg_pkg::*; #(
  parameter int T1_MAX_CYC = `RXC_T1_MAX_CYC
) (
  input logic sys_clk,
  input logic rst_n,
  input logic data_in,
  output logic data_out,
  output logic data_oe,
  input logic enable_in,
  input logic bit_check_ok,
  input logic bit_check_fail,
  input logic brownout_det,
  output logic aux_output_pin,
  output rxcfg_pwr_t power_mode,
  output logic off_cmd_done,
  output logic lost_config_marker,
  output logic [1:0] rate_band_select,
  output logic [3:0] window_scale_factor,
  output logic [3:0] bits_to_check,
  output logic [8:0] lim_min_cycles,
  output logic [8:0] lim_max_cycles
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and quiet-time tracking
  logic data_s1_reg, data_s2_reg, en_s1_reg, en_s2_reg, en_d_reg;
  logic [1:0] quiet_reg;
  logic oe_reg;

  // Quiet guard: our own released low must not look like a command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_s1_reg <= 1'b1;
      data_s2_reg <= 1'b1;
      en_s1_reg <= 1'b1;
      en_s2_reg <= 1'b1;
      en_d_reg <= 1'b1;
      quiet_reg <= 2'h0;
    end else begin
      data_s1_reg <= data_in;
      data_s2_reg <= data_s1_reg;
      en_s1_reg <= enable_in;
      en_s2_reg <= en_s1_reg;
      en_d_reg <= en_s2_reg;
      quiet_reg <= oe_reg ? 2'h0 : ((quiet_reg == 2'h3) ? quiet_reg : quiet_reg + 2'h1);
    end
  end

  logic ext_low, en_rise;
  assign ext_low = !data_s2_reg && (quiet_reg == 2'h3);
  assign en_rise = en_s2_reg && !en_d_reg;

  ////////////////////////////////////////////////////////////////////////
  // Command receiver and configuration registers
  rxcfg_cmd_t cmd_reg, cmd_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [3:0] idx_reg, idx_next;
  logic [10:0] shift_reg, shift_next;
  logic sel_reg, sel_next;
  logic [11:0] op_reg, op_next, lim_reg, lim_next;
  logic mark_reg, mark_next, wop_reg, wop_next, wlim_reg, wlim_next;
  logic revert_reg, revert_next, oe_next, off_reg, off_next;
  logic [15:0] rm_reg, rm_next, t1_min;
  logic bit_val;

  assign rate_band_select = op_reg[`RXC_OP_BAND_HI:`RXC_OP_BAND_LO];
  assign window_scale_factor = 4'(4'h8 >> rate_band_select); // R15
  assign t1_min = 16'(`RXC_T1_UNIT_CYC) * {12'h0, window_scale_factor}; // R2
  assign bit_val = data_s2_reg;

  always_comb begin
    cmd_next = cmd_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    shift_next = shift_reg;
    sel_next = sel_reg;
    op_next = op_reg;
    lim_next = lim_reg;
    mark_next = mark_reg;
    wop_next = wop_reg;
    wlim_next = wlim_reg;
    revert_next = revert_reg;
    oe_next = 1'b0;
    off_next = 1'b0;
    rm_next = (rm_reg == 16'(`RXC_RM_PER_CYC - 1)) ? 16'h0 : rm_reg + 16'h1;
    unique case (cmd_reg)
      RXCFG_C_IDLE: begin
        if (ext_low) begin
          cmd_next = RXCFG_C_LOW;
          cnt_next = 16'h0;
        end else begin
          oe_next = mark_reg && (rm_next < 16'(`RXC_RM_LOW_CYC)); // R10
        end
      end
      RXCFG_C_LOW: begin
        if (cnt_reg != 16'hffff) begin
          cnt_next = cnt_reg + 16'h1;
        end
        if (cnt_reg == 16'(T1_MAX_CYC)) begin
          mark_next = 1'b0; // R3
        end
        if (data_s2_reg) begin
          cnt_next = 16'h0;
          idx_next = 4'h0;
          // Too short a low is ignored as a glitch
          cmd_next = (cnt_reg >= t1_min) ? RXCFG_C_GAP : RXCFG_C_IDLE; // R2
        end
      end
      RXCFG_C_GAP: begin
        cnt_next = cnt_reg + 16'h1;
        if (cnt_reg == 16'(`RXC_T2_CYC - 1)) begin
          cmd_next = RXCFG_C_SYNC;
          cnt_next = 16'h0;
          oe_next = 1'b1;
        end
      end
      RXCFG_C_SYNC: begin
        cnt_next = cnt_reg + 16'h1;
        oe_next = 1'b1; // R23
        if (cnt_reg == 16'(`RXC_T3_CYC - 1)) begin
          cmd_next = RXCFG_C_BIT;
          cnt_next = 16'h0;
          oe_next = 1'b0;
        end
      end
      RXCFG_C_BIT: begin
        cnt_next = cnt_reg + 16'h1;
        if (cnt_reg == 16'(`RXC_TBIT_CYC - 1)) begin
          cnt_next = 16'h0;
          idx_next = idx_reg + 4'h1;
          cmd_next = RXCFG_C_SYNC;
          oe_next = 1'b1;
          if (idx_reg == 4'h0) begin
            if (bit_val) begin
              cmd_next = RXCFG_C_TAIL; // R4 R12
              oe_next = 1'b0;
            end
          end else if (idx_reg == 4'h1) begin
            sel_next = bit_val; // R12
          end else begin
            shift_next = {shift_reg[9:0], bit_val}; // R23
            if (idx_reg == `RXC_FRAME_LAST) begin
              cmd_next = RXCFG_C_IDLE;
              oe_next = 1'b0;
              // Last field bit completes the write
              if (sel_reg) begin
                op_next = {shift_reg, bit_val}; // R9 R13
                wop_next = 1'b1;
                revert_next = 1'b0;
              end else begin
                lim_next = {shift_reg, bit_val}; // R9 R14
                wlim_next = 1'b1;
              end
            end
          end
        end
      end
      RXCFG_C_TAIL: begin
        cnt_next = cnt_reg + 16'h1;
        if (cnt_reg == 16'(`RXC_T10_CYC - 1)) begin
          cmd_next = RXCFG_C_IDLE;
          off_next = 1'b1; // R5
        end
      end
      default: begin
        cmd_next = RXCFG_C_IDLE;
      end
    endcase
    // Marker clears once both registers have been rewritten
    if (mark_reg && wop_next && wlim_next) begin
      mark_next = 1'b0; // R10
    end
    // Failure set wins over the clear by an operating write
    if (bit_check_fail && op_reg[`RXC_OP_XTMP] && !op_reg[`RXC_OP_XSTD]) begin
      revert_next = 1'b1; // R20
    end
    if (brownout_det) begin
      op_next = `RXC_OP_RESET;
      lim_next = `RXC_LIM_RESET;
      mark_next = 1'b1; // R10
      wop_next = 1'b0;
      wlim_next = 1'b0;
      revert_next = 1'b0;
    end
  end

  // Defaults at reset give a working receiver without programming
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= RXCFG_C_IDLE;
      cnt_reg <= 16'h0;
      idx_reg <= 4'h0;
      shift_reg <= 11'h0;
      sel_reg <= 1'b0;
      op_reg <= `RXC_OP_RESET; // R11
      lim_reg <= `RXC_LIM_RESET; // R11
      mark_reg <= 1'b0;
      wop_reg <= 1'b0;
      wlim_reg <= 1'b0;
      revert_reg <= 1'b0;
      oe_reg <= 1'b0;
      off_reg <= 1'b0;
      rm_reg <= 16'h0;
    end else begin
      cmd_reg <= cmd_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      shift_reg <= shift_next;
      sel_reg <= sel_next;
      op_reg <= op_next;
      lim_reg <= lim_next;
      mark_reg <= mark_next;
      wop_reg <= wop_next;
      wlim_reg <= wlim_next;
      revert_reg <= revert_next;
      oe_reg <= oe_next;
      off_reg <= off_next;
      rm_reg <= rm_next;
    end
  end

  // Open drain: only ever pull low
  assign data_out = 1'b0;
  assign data_oe = oe_reg;
  assign off_cmd_done = off_reg;
  assign lost_config_marker = mark_reg;
  assign aux_output_pin = op_reg[`RXC_OP_AUX_OUTPUT_PIN]; // R18

  logic [1:0] chk;
  logic [5:0] lmin, lmax;
  assign chk = op_reg[`RXC_OP_CHK_HI:`RXC_OP_CHK_LO];
  assign bits_to_check = {1'b0, chk, 1'b0} + {2'h0, chk}; // R17
  assign lmin = lim_reg[`RXC_LIM_MIN_HI:`RXC_LIM_MIN_LO];
  assign lmax = lim_reg[`RXC_LIM_MAX_HI:`RXC_LIM_MAX_LO];
  // Upper limit minus one; a zero value wraps, controller keeps it >= 12
  assign lim_min_cycles = 9'({3'h0, lmin} << (2'h3 - rate_band_select)); // R16 R21
  assign lim_max_cycles = 9'({3'h0, lmax - 6'h1} << (2'h3 - rate_band_select)); // R16 R21

  ////////////////////////////////////////////////////////////////////////
  // Power state and sleep timer
  rxcfg_pwr_t pwr_reg, pwr_next;
  logic [17:0] slp_reg, slp_next, slp_load;
  logic [4:0] slp_val;
  logic x8;

  assign slp_val = op_reg[`RXC_OP_SLP_HI:`RXC_OP_SLP_LO];
  assign x8 = op_reg[`RXC_OP_XSTD] || (op_reg[`RXC_OP_XTMP] && !revert_reg); // R20
  assign slp_load = 18'({13'h0, slp_val} << (x8 ? 4'd13 : 4'd10)); // R19

  always_comb begin
    pwr_next = pwr_reg;
    slp_next = slp_reg;
    if (!en_s2_reg || en_rise || off_reg) begin
      // Low enable holds the timer loaded, so counting starts at the edge
      pwr_next = RXCFG_P_SLEEP; // R1 R6 R7
      slp_next = slp_load; // R5 R6
    end else begin
      unique case (pwr_reg)
        RXCFG_P_POLL: begin
          if (bit_check_ok) begin
            pwr_next = RXCFG_P_RECV;
          end else if (bit_check_fail) begin
            pwr_next = RXCFG_P_SLEEP;
            slp_next = slp_load;
          end
        end
        RXCFG_P_RECV: begin
          pwr_next = RXCFG_P_RECV;
        end
        RXCFG_P_SLEEP: begin
          if (slp_val != `RXC_SLEEP_PERM) begin // R19
            if (slp_reg == 18'h0) begin
              pwr_next = RXCFG_P_POLL;
            end else begin
              slp_next = slp_reg - 18'h1;
            end
          end
        end
        default: begin
          pwr_next = RXCFG_P_POLL;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= RXCFG_P_POLL;
      slp_reg <= 18'h0;
    end else begin
      pwr_reg <= pwr_next;
      slp_reg <= slp_next;
    end
  end

  assign power_mode = pwr_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sync_start;
    cmd_reg == RXCFG_C_SYNC && cnt_reg == 16'h0;
  endsequence
  sequence s_sync_held;
    data_oe [*8];
  endsequence

  property p_sync_pulse;
    s_sync_start |-> s_sync_held;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse short"); // R23

  property p_off_one_sync;
    cmd_reg == RXCFG_C_TAIL |-> !data_oe && idx_reg == 4'h1;
  endproperty
  a_off_one_sync: assert property (p_off_one_sync) else $error("extra sync in off"); // R4

  property p_off_sleep;
    off_cmd_done && en_s2_reg |=> power_mode == RXCFG_P_SLEEP && slp_reg == $past(slp_load);
  endproperty
  a_off_sleep: assert property (p_off_sleep) else $error("off did not sleep"); // R5

  property p_en_low;
    !en_s2_reg |=> power_mode == RXCFG_P_SLEEP;
  endproperty
  a_en_low: assert property (p_en_low) else $error("awake while enable low"); // R7

  property p_en_rise;
    en_rise |=> slp_reg == $past(slp_load);
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("sleep not started"); // R6

  property p_perm_sleep;
    power_mode == RXCFG_P_SLEEP && slp_val == 5'h1f |=> power_mode == RXCFG_P_SLEEP;
  endproperty
  a_perm_sleep: assert property (p_perm_sleep) else $error("left permanent sleep"); // R19

  property p_brownout;
    brownout_det |=> lost_config_marker && op_reg == 12'h22c && lim_reg == 12'h398;
  endproperty
  a_brownout: assert property (p_brownout) else $error("brownout not flagged"); // R10

  property p_limit_keeps_op;
    cmd_reg == RXCFG_C_BIT && idx_reg == 4'hd && !sel_reg |=> $stable(op_reg);
  endproperty
  a_limit_keeps_op: assert property (p_limit_keeps_op) else $error("wrong register"); // R12

  property p_fast_band;
    rate_band_select == 2'h3 |-> lim_min_cycles == {3'h0, lmin};
  endproperty
  a_fast_band: assert property (p_fast_band) else $error("bad scaling"); // R16

  property p_temp_revert;
    bit_check_fail && op_reg[0] && !op_reg[1] && !brownout_det |=> !x8;
  endproperty
  a_temp_revert: assert property (p_temp_revert) else $error("factor kept"); // R20
endmodule

// File: include/rxcfg_consts.svh
/*
  Constants of the receiver configuration and off-command logic: field
  positions, reset values and line timing. Assumes a 100 ns system clock.
*/
`ifndef RXCFG_CONSTS_SVH
`define RXCFG_CONSTS_SVH
`define RXC_CLK_NS 100
// Least times round up, longest times round down
`define RXC_T1_UNIT_NS 12500
`define RXC_T1_UNIT_CYC ((`RXC_T1_UNIT_NS + `RXC_CLK_NS - 1) / `RXC_CLK_NS)
`define RXC_T1_MAX_NS 5000000
`define RXC_T1_MAX_CYC (`RXC_T1_MAX_NS / `RXC_CLK_NS)
`define RXC_T2_NS 20000
`define RXC_T2_CYC ((`RXC_T2_NS + `RXC_CLK_NS - 1) / `RXC_CLK_NS)
`define RXC_T3_NS 10000
`define RXC_T3_CYC ((`RXC_T3_NS + `RXC_CLK_NS - 1) / `RXC_CLK_NS)
`define RXC_TBIT_NS 40000
`define RXC_TBIT_CYC ((`RXC_TBIT_NS + `RXC_CLK_NS - 1) / `RXC_CLK_NS)
`define RXC_T10_NS 20000
`define RXC_T10_CYC ((`RXC_T10_NS + `RXC_CLK_NS - 1) / `RXC_CLK_NS)
`define RXC_RM_PER_NS 200000
`define RXC_RM_PER_CYC (`RXC_RM_PER_NS / `RXC_CLK_NS)
`define RXC_RM_LOW_NS 20000
`define RXC_RM_LOW_CYC (`RXC_RM_LOW_NS / `RXC_CLK_NS)
`define RXC_SLEEP_SHIFT 10
`define RXC_SLEEP_PERM 5'h1f
`define RXC_FRAME_LAST 4'hd
// Field positions inside the 12-bit registers
`define RXC_OP_BAND_HI 11
`define RXC_OP_BAND_LO 10
`define RXC_OP_CHK_HI 9
`define RXC_OP_CHK_LO 8
`define RXC_OP_AUX_OUTPUT_PIN 7
`define RXC_OP_SLP_HI 6
`define RXC_OP_SLP_LO 2
`define RXC_OP_XSTD 1
`define RXC_OP_XTMP 0
`define RXC_LIM_MIN_HI 11
`define RXC_LIM_MIN_LO 6
`define RXC_LIM_MAX_HI 5
`define RXC_LIM_MAX_LO 0
`define RXC_OP_RESET 12'h22c
`define RXC_LIM_RESET 12'h398
`endif

// File: include/rxcfg_pkg.sv
/*
  Types of the receiver configuration logic. Assumes nothing else.
*/
package rxcfg_pkg;
  typedef enum logic [2:0] {
    RXCFG_C_IDLE = 3'b000,
    RXCFG_C_LOW = 3'b001,
    RXCFG_C_GAP = 3'b010,
    RXCFG_C_SYNC = 3'b011,
    RXCFG_C_BIT = 3'b100,
    RXCFG_C_TAIL = 3'b101
  } rxcfg_cmd_t;
  typedef enum logic [1:0] {
    RXCFG_P_POLL = 2'b00,
    RXCFG_P_RECV = 2'b01,
    RXCFG_P_SLEEP = 2'b10
  } rxcfg_pwr_t;
endpackage

// File: verification/rxcfg_ctrl_model.sv
/*
  Controller model on the receiver's shared data line: start interval and
  command frames. Assumes the bench merges both pull-downs with a pull-up.
*/
`timescale 1ns/1ps
module rxcfg_ctrl_model (
  input wire logic sys_clk,
  input wire logic dev_pull,
  output logic ctrl_pull
);
  initial begin
    ctrl_pull = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Start interval; waits for the receiver to let go of the line first
  task automatic start_low(input int cyc);
    int k;
    k = 0;
    while (dev_pull && k < 3000) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (10) @(posedge sys_clk);
    #5 ctrl_pull = 1'b1;
    repeat (cyc) @(posedge sys_clk);
    #5 ctrl_pull = 1'b0;
  endtask

  // One bit per sync, first bit first; a 1 is just a released line
  task automatic send_frame(input logic [13:0] frame, input int nbits);
    int k;
    start_low(1100);
    for (int i = 0; i < nbits; i++) begin
      k = 0;
      while (!dev_pull && k < 1000) begin
        @(negedge sys_clk);
        k++;
      end
      while (dev_pull && k < 2000) begin
        @(negedge sys_clk);
        k++;
      end
      @(posedge sys_clk);
      // Held past the sample point to cover the receiver's synchroniser lag
      #5 ctrl_pull = ~frame[13 - i];
      repeat (402) @(posedge sys_clk);
      #5 ctrl_pull = 1'b0;
    end
  endtask
endmodule

// File: verification/test_rx_config_and_off_command.sv
/*
  Testbench of the receiver configuration and off-command logic. Assumes
  the core and the controller model; line has a pull-up.
*/
`timescale 1ns/1ps
module test_rx_config_and_off_command import rxcfg_pkg::*; ;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic enable_in = 1'b1;
  logic bit_check_ok = 1'b0;
  logic bit_check_fail = 1'b0;
  logic brownout_det = 1'b0;
  logic data_out, data_oe, aux_output_pin, off_cmd_done, lost_config_marker;
  logic ctrl_pull, oe_seen, done_seen;
  rxcfg_pwr_t power_mode;
  logic [1:0] rate_band_select;
  logic [3:0] window_scale_factor, bits_to_check;
  logic [8:0] lim_min_cycles, lim_max_cycles;
  int err_count = 0;
  int samples_checked = 0;
  // Open-drain line: either party pulling wins
  wire dev_pull = data_oe & ~data_out;
  wire data_in = ~(dev_pull | ctrl_pull);

  always #50 sys_clk = ~sys_clk;

  // Smaller overlong limit keeps the marker-erase case short
  rxcfg_core #(.T1_MAX_CYC(2000)) i_rxcfg_core (.sys_clk(sys_clk), .rst_n(rst_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .enable_in(enable_in),
    .bit_check_ok(bit_check_ok), .bit_check_fail(bit_check_fail),
    .brownout_det(brownout_det), .aux_output_pin(aux_output_pin),
    .power_mode(power_mode), .off_cmd_done(off_cmd_done),
    .lost_config_marker(lost_config_marker), .rate_band_select(rate_band_select),
    .window_scale_factor(window_scale_factor), .bits_to_check(bits_to_check),
    .lim_min_cycles(lim_min_cycles), .lim_max_cycles(lim_max_cycles));
  rxcfg_ctrl_model i_rxcfg_ctrl_model (.sys_clk(sys_clk), .dev_pull(dev_pull),
    .ctrl_pull(ctrl_pull));

  ////////////////////////////////////////////////////////////////////////
  // Compare, wait and verdict helpers
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask
  task automatic end_sim();
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cfg_check(input int b, input int mn, input int mx);
    check("band", rate_band_select, 12'(b));
    check("factor", window_scale_factor, 12'(8 >> b));
    check("lim_min", lim_min_cycles, 12'(mn * (8 >> b)));
    check("lim_max", lim_max_cycles, 12'((mx - 1) * (8 >> b)));
  endtask
  task automatic pulse_ok();
    bit_check_ok = 1'b1;
    cyc(1);
    bit_check_ok = 1'b0;
    cyc(3);
    check("mode", power_mode, RXCFG_P_RECV);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(6);
    rst_n = 1'b1;
    cyc(2);
    cfg_check(0, 14, 24);
    check("checked", bits_to_check, 12'h006);
    check("aux", aux_output_pin, 12'h000);
    check("mode", power_mode, RXCFG_P_POLL);
    // Every band and count code, sleep value 1
    for (int b = 0; b < 4; b++) begin
      i_rxcfg_ctrl_model.send_frame({2'b01, b[1:0], b[1:0], b[0], 5'h01, 2'b00}, 14);
      cyc(5);
      cfg_check(b, 14, 24);
      check("checked", bits_to_check, 12'(3 * b));
      check("aux", aux_output_pin, 12'(b[0]));
    end
    // Smallest legal limits at factor 1
    i_rxcfg_ctrl_model.send_frame({2'b00, 6'h0a, 6'h0c}, 14);
    cyc(5);
    cfg_check(3, 10, 12);
    // Off command from receiving mode: single sync, then sleep time
    pulse_ok();
    i_rxcfg_ctrl_model.send_frame(14'h2000, 1);
    oe_seen = 1'b0;
    done_seen = 1'b0;
    for (int k = 0; k < 400 && !done_seen; k++) begin
      cyc(1);
      oe_seen = oe_seen | data_oe;
      done_seen = off_cmd_done;
    end
    check("off_done", done_seen, 12'h001);
    check("extra_sync", oe_seen, 12'h000);
    cyc(1);
    check("mode", power_mode, RXCFG_P_SLEEP);
    cyc(1000);
    check("mode", power_mode, RXCFG_P_SLEEP);
    cyc(60);
    check("mode", power_mode, RXCFG_P_POLL);
    // Enable pin held low well past the sleep time
    pulse_ok();
    enable_in = 1'b0;
    cyc(5);
    check("mode", power_mode, RXCFG_P_SLEEP);
    cyc(2000);
    check("mode", power_mode, RXCFG_P_SLEEP);
    enable_in = 1'b1;
    cyc(1000);
    check("mode", power_mode, RXCFG_P_SLEEP);
    cyc(60);
    check("mode", power_mode, RXCFG_P_POLL);
    // Controller-only polling: sleep value 0 answers at once, temporary factor
    i_rxcfg_ctrl_model.send_frame({2'b01, 2'b11, 2'b11, 1'b1, 5'h00, 2'b01}, 14);
    cyc(5);
    check("aux", aux_output_pin, 12'h001);
    bit_check_fail = 1'b1;
    cyc(1);
    bit_check_fail = 1'b0;
    cyc(3);
    check("mode", power_mode, RXCFG_P_POLL);
    enable_in = 1'b0;
    cyc(5);
    check("mode", power_mode, RXCFG_P_SLEEP);
    enable_in = 1'b1;
    cyc(5);
    check("mode", power_mode, RXCFG_P_POLL);
    // Lost contents: defaults back, marker on the line, overlong low clears it
    brownout_det = 1'b1;
    cyc(1);
    brownout_det = 1'b0;
    cyc(3);
    check("marker", lost_config_marker, 12'h001);
    cfg_check(0, 14, 24);
    oe_seen = 1'b0;
    for (int k = 0; k < 2100 && !oe_seen; k++) begin
      cyc(1);
      oe_seen = data_oe;
    end
    check("marker_line", oe_seen, 12'h001);
    i_rxcfg_ctrl_model.start_low(2500);
    cyc(5);
    check("marker", lost_config_marker, 12'h000);
    end_sim();
  end

  // Watchdog sized well above the expected run of about 60000 cycles
  initial begin
    repeat (95000) @(posedge sys_clk);
    err_count++;
    $display("Error watchdog expired before the tests ended");
    end_sim();
  end
endmodule
